/* common/vtr_regs.svh */
/*
 Offsets, field positions, reset values and timing counts of the vector table
 relocation block. Assumes byte addressing on a 32-bit AXI4-Lite register bus.
*/
`ifndef VTR_REGS_SVH
`define VTR_REGS_SVH

// Register bus geometry
`define VTR_ADDR_W        8
`define VTR_CTRL_OFS      8'h00
`define VTR_RESP_OKAY     2'h0
`define VTR_RESP_SLVERR   2'h2

// General interrupt control layout
`define VTR_CTRL_RST      8'h00
`define VTR_BIT_UNLOCK    0
`define VTR_BIT_SEL       1
`define VTR_BIT_RSVD      2
`define VTR_EN_LSB        3
`define VTR_EN_MSB        7

// Unlock window length in clock-enabled cycles
`define VTR_UNLOCK_CYCLES 3'h4

// Vector address width in bits
`define VTR_VEC_W         16

`endif

/* common/vtr_pkg.sv */
/*
 Types of the vector table relocation block: sequencer states and the state
 records of the top and of the vector gate. Assumes vtr_regs.svh for widths.
*/
`include "vtr_regs.svh"

package vtr_pkg;

   // Unlock sequencer states
   typedef enum logic [1:0] {
      VTR_IDLE = 2'b00,
      VTR_OPEN = 2'b01,
      VTR_HOLD = 2'b10
   } vtr_seq_t;

   // All state of the top module
   typedef struct packed {
      vtr_seq_t    seq;
      logic [2:0]  cnt;
      logic        sel;
      logic [4:0]  en;
      logic        mask;
      logic        aw_got;
      logic        w_got;
      logic [7:0]  waddr;
      logic [7:0]  wdata;
      logic        wstrb0;
      logic        awready;
      logic        wready;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        arready;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
   } vtr_state_t;

   // All state of the vector gate
   typedef struct packed {
      logic [`VTR_VEC_W-1:0] vec_addr;
      logic                  block;
   } vtr_gate_t;

endpackage

/* src/vtr_gate.sv */
/*
 Vector gate: forms the fetched vector address and the interrupt block level.
 Assumes sel and seq_mask are the next-cycle values from the control logic.
*/
`timescale 1ns/100ps
`include "vtr_regs.svh"

module vtr_gate (
   // Clock and reset
   input  wire logic                  clk,
   input  wire logic                  rst,
   input  wire logic                  ce,
   // Control
   input  wire logic                  sel,
   input  wire logic                  seq_mask,
   // Lock bits and execution section
   input  wire logic                  app_lock,
   input  wire logic                  boot_lock,
   input  wire logic                  exec_boot,
   // Vector request
   input  wire logic [`VTR_VEC_W-1:0] boot_base,
   input  wire logic [`VTR_VEC_W-1:0] vec_offset,
   output logic      [`VTR_VEC_W-1:0] vec_addr,
   output logic                       irq_block
);

   vtr_pkg::vtr_gate_t r;
   vtr_pkg::vtr_gate_t next_r;

   // Address select and blocking terms
   always_comb begin
      next_r = r;
      if (sel) begin
         next_r.vec_addr = `VTR_VEC_W'(boot_base + vec_offset);
      end else begin
         next_r.vec_addr = vec_offset;
      end
      // Own block level only; the global enable flag is never touched
      next_r.block = seq_mask
                   | (sel & app_lock & ~exec_boot)
                   | (~sel & boot_lock & exec_boot);
   end

   // State register
   always_ff @(posedge clk) begin
      if (rst) begin
         r <= '0;
      end else if (ce) begin
         r <= next_r;
      end
   end

   assign vec_addr  = r.vec_addr;
   assign irq_block = r.block;

endmodule // vtr_gate

/* src/vtr_top.sv */
/*
 Vector table relocation control: general interrupt control register on an
 AXI4-Lite slave, timed unlock of the vector select, automatic masking and
 lock-bit blocking. Assumes one clock, synchronous inputs, and a core that
 pulses INSTR_DONE as each instruction completes.
*/
// How it works
// - Select zero: vectors come from the start of program flash.
// - Select one: vectors come from the boot section base given by fuses.
// - Mask interrupts from unlock set until the instruction after the select write.
// - Without a select write, mask for four cycles then release.
// - Automatic masking leaves the global interrupt enable flag untouched.
// - Unlock clears after four cycles, or at once on a select write.
// - Boot vectors plus application lock: block interrupts while running application.
// - Application vectors plus boot lock: block interrupts while running boot code.
// - Register bits: five enables, reserved zero, select bit 1, unlock bit 0.
// - Relocated vector address is table offset plus boot section start.
`timescale 1ns/100ps
`include "vtr_regs.svh"

module vtr_top (
   // Clock, reset, enable
   input  wire logic                  CORE_CLK,
   input  wire logic                  RST,
   input  wire logic                  CE,
   // AXI4-Lite write address and data
   input  wire logic                  S_AXI_AWVALID,
   output logic                       S_AXI_AWREADY,
   input  wire logic [`VTR_ADDR_W-1:0] S_AXI_AWADDR,
   input  wire logic                  S_AXI_WVALID,
   output logic                       S_AXI_WREADY,
   input  wire logic [31:0]           S_AXI_WDATA,
   input  wire logic [3:0]            S_AXI_WSTRB,
   // AXI4-Lite write response
   output logic                       S_AXI_BVALID,
   input  wire logic                  S_AXI_BREADY,
   output logic      [1:0]            S_AXI_BRESP,
   // AXI4-Lite read
   input  wire logic                  S_AXI_ARVALID,
   output logic                       S_AXI_ARREADY,
   input  wire logic [`VTR_ADDR_W-1:0] S_AXI_ARADDR,
   output logic                       S_AXI_RVALID,
   input  wire logic                  S_AXI_RREADY,
   output logic      [31:0]           S_AXI_RDATA,
   output logic      [1:0]            S_AXI_RRESP,
   // Core and flash status
   input  wire logic                  INSTR_DONE,
   input  wire logic                  APP_LOCK,
   input  wire logic                  BOOT_LOCK,
   input  wire logic                  EXEC_BOOT,
   input  wire logic [`VTR_VEC_W-1:0] BOOT_BASE,
   input  wire logic [`VTR_VEC_W-1:0] VEC_OFFSET,
   // Control outputs
   output logic      [4:0]            IRQ_ENABLE,
   output logic                       VEC_SELECT,
   output logic      [`VTR_VEC_W-1:0] VEC_ADDR,
   output logic                       IRQ_BLOCK
);

   vtr_pkg::vtr_state_t r;
   vtr_pkg::vtr_state_t next_r;
   logic                wr_fire;
   logic                wr_hit;
   logic [7:0]          ctrl_rd;

   // Single mapped word decode
   function automatic logic vtr_hit(input logic [`VTR_ADDR_W-1:0] a);
      vtr_hit = (a == `VTR_CTRL_OFS);
   endfunction

   // Write happens once both halves are held
   assign wr_fire = r.aw_got & r.w_got & ~r.bvalid;
   assign wr_hit  = wr_fire & vtr_hit(r.waddr) & r.wstrb0;

   // Register readback, reserved bit reads zero
   assign ctrl_rd = {r.en, 1'b0, r.sel, (r.seq == vtr_pkg::VTR_OPEN)};

   // Next-state logic
   always_comb begin
      next_r = r;
      // Capture write address and data in either order
      if (S_AXI_AWVALID && r.awready) begin
         next_r.aw_got = 1'b1;
         next_r.waddr  = S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && r.wready) begin
         next_r.w_got  = 1'b1;
         next_r.wdata  = S_AXI_WDATA[7:0];
         next_r.wstrb0 = S_AXI_WSTRB[0];
      end
      if (wr_fire) begin
         next_r.aw_got = 1'b0;
         next_r.w_got  = 1'b0;
         next_r.bvalid = 1'b1;
         next_r.bresp  = vtr_hit(r.waddr) ? `VTR_RESP_OKAY : `VTR_RESP_SLVERR;
      end
      if (r.bvalid && S_AXI_BREADY) begin
         next_r.bvalid = 1'b0;
      end
      next_r.awready = ~next_r.aw_got & ~next_r.bvalid;
      next_r.wready  = ~next_r.w_got & ~next_r.bvalid;
      // Read channel
      if (S_AXI_ARVALID && r.arready) begin
         next_r.rvalid = 1'b1;
         next_r.rdata  = vtr_hit(S_AXI_ARADDR) ? {24'h000000, ctrl_rd} : 32'h00000000;
         next_r.rresp  = vtr_hit(S_AXI_ARADDR) ? `VTR_RESP_OKAY : `VTR_RESP_SLVERR;
      end
      if (r.rvalid && S_AXI_RREADY) begin
         next_r.rvalid = 1'b0;
      end
      next_r.arready = ~next_r.rvalid;
      // Enable bits write straight through
      if (wr_hit) begin
         next_r.en = r.wdata[`VTR_EN_MSB:`VTR_EN_LSB];
      end
      // Unlock sequencer
      case (r.seq)
         vtr_pkg::VTR_IDLE: begin
            if (wr_hit && r.wdata[`VTR_BIT_UNLOCK]) begin
               next_r.seq = vtr_pkg::VTR_OPEN;
               next_r.cnt = `VTR_UNLOCK_CYCLES;
            end
         end
         vtr_pkg::VTR_OPEN: begin
            if (wr_hit && r.wdata[`VTR_BIT_UNLOCK]) begin
               next_r.cnt = `VTR_UNLOCK_CYCLES;
            end else if (wr_hit) begin
               next_r.sel = r.wdata[`VTR_BIT_SEL];
               next_r.seq = vtr_pkg::VTR_HOLD;
            end else if (r.cnt == 3'h1) begin
               next_r.seq = vtr_pkg::VTR_IDLE;
            end else begin
               next_r.cnt = r.cnt - 3'h1;
            end
         end
         vtr_pkg::VTR_HOLD: begin
            if (wr_hit && r.wdata[`VTR_BIT_UNLOCK]) begin
               next_r.seq = vtr_pkg::VTR_OPEN;
               next_r.cnt = `VTR_UNLOCK_CYCLES;
            end else if (INSTR_DONE) begin
               next_r.seq = vtr_pkg::VTR_IDLE;
            end
         end
         default: begin
            next_r.seq = vtr_pkg::VTR_IDLE;
         end
      endcase
      // Sequence mask while the window is open or the select write is held
      next_r.mask = (next_r.seq != vtr_pkg::VTR_IDLE);
   end

   // State register
   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         r <= '0;
      end else if (CE) begin
         r <= next_r;
      end
   end

   // Vector address and block level
   vtr_gate u_gate (
      .clk        (CORE_CLK),
      .rst        (RST),
      .ce         (CE),
      .sel        (next_r.sel),
      .seq_mask   (next_r.mask),
      .app_lock   (APP_LOCK),
      .boot_lock  (BOOT_LOCK),
      .exec_boot  (EXEC_BOOT),
      .boot_base  (BOOT_BASE),
      .vec_offset (VEC_OFFSET),
      .vec_addr   (VEC_ADDR),
      .irq_block  (IRQ_BLOCK)
   );

   // Port drive
   assign S_AXI_AWREADY = r.awready;
   assign S_AXI_WREADY  = r.wready;
   assign S_AXI_BVALID  = r.bvalid;
   assign S_AXI_BRESP   = r.bresp;
   assign S_AXI_ARREADY = r.arready;
   assign S_AXI_RVALID  = r.rvalid;
   assign S_AXI_RDATA   = r.rdata;
   assign S_AXI_RRESP   = r.rresp;
   assign IRQ_ENABLE    = r.en;
   assign VEC_SELECT    = r.sel;

   // Checks
   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (RST);

   logic unlock_go;
   assign unlock_go = CE & wr_hit & r.wdata[`VTR_BIT_UNLOCK] & (r.seq == vtr_pkg::VTR_IDLE);

   AST_UNLOCK_MASKS: assert property (unlock_go |=> IRQ_BLOCK && r.mask)
      else $error("block not raised with unlock");
   AST_UNLOCK_HOLDS: assert property (unlock_go ##1 (CE && !wr_fire)[*3] |=> r.seq == vtr_pkg::VTR_OPEN)
      else $error("unlock cleared early");
   AST_UNLOCK_TIMEOUT: assert property (unlock_go ##1 (CE && !wr_fire)[*4] |=> !r.mask && r.seq == vtr_pkg::VTR_IDLE)
      else $error("unlock window not closed after four cycles");
   AST_SEL_LOCKED: assert property (CE && r.seq != vtr_pkg::VTR_OPEN |=> $stable(r.sel))
      else $error("select changed outside window");
   AST_SEL_WRITE: assert property (CE && wr_hit && r.seq == vtr_pkg::VTR_OPEN && !r.wdata[0]
      |=> r.sel == $past(r.wdata[1]) && r.seq == vtr_pkg::VTR_HOLD)
      else $error("select write not applied");
   AST_HOLD_MASK: assert property (CE && r.seq == vtr_pkg::VTR_HOLD && !INSTR_DONE && !wr_hit |=> IRQ_BLOCK)
      else $error("mask dropped before instruction completed");
   AST_BLOCK_APP: assert property (CE && next_r.sel && APP_LOCK && !EXEC_BOOT |=> IRQ_BLOCK)
      else $error("application code not blocked");
   AST_BLOCK_BOOT: assert property (CE && !next_r.sel && BOOT_LOCK && EXEC_BOOT |=> IRQ_BLOCK)
      else $error("boot code not blocked");
   AST_VEC_ADDR: assert property (CE |=> VEC_ADDR == ($past(next_r.sel)
      ? `VTR_VEC_W'($past(BOOT_BASE) + $past(VEC_OFFSET)) : $past(VEC_OFFSET)))
      else $error("vector address wrong");
   AST_RSVD_ZERO: assert property (S_AXI_RVALID |-> !S_AXI_RDATA[`VTR_BIT_RSVD])
      else $error("reserved bit read as one");
   // Low clock enable freezes the sequencer, the bus state and the gate
   AST_CE_FREEZE: assert property (!CE |=> $stable(r)
      && $stable(VEC_ADDR) && $stable(IRQ_BLOCK))
      else $error("state moved while clock enable low");

   COV_TIMEOUT: cover property (unlock_go ##1 (CE && !wr_fire)[*4] ##1 !r.mask);
   COV_MOVE: cover property (unlock_go ##[1:4] (wr_hit && r.wdata[1]) ##1 r.sel);
   COV_APP_BLOCK: cover property (r.sel && APP_LOCK && !EXEC_BOOT ##1 IRQ_BLOCK);
   COV_FROZEN_WINDOW: cover property (r.seq == vtr_pkg::VTR_OPEN && !CE ##1 r.seq == vtr_pkg::VTR_OPEN);

endmodule // vtr_top

/* sim/vtr_core_model.sv */
/*
 Core model: register writes and reads over AXI4-Lite, and instruction
 completion pulses. Assumes response ready lines are held high outside.
*/
`timescale 1ns/100ps

module vtr_core_model (
   // Clock
   input  wire logic        clk,
   // Write channels
   output logic             aw_valid,
   input  wire logic        aw_ready,
   output logic [7:0]       aw_addr,
   output logic             w_valid,
   input  wire logic        w_ready,
   output logic [31:0]      w_data,
   output logic [3:0]       w_strb,
   input  wire logic        b_valid,
   input  wire logic [1:0]  b_resp,
   // Read channels
   output logic             ar_valid,
   input  wire logic        ar_ready,
   output logic [7:0]       ar_addr,
   input  wire logic        r_valid,
   input  wire logic [31:0] r_data,
   input  wire logic [1:0]  r_resp,
   // Instruction completion
   output logic             done
);
   // Idle levels
   initial begin
      {aw_valid, w_valid, ar_valid, done} = 4'h0;
      {aw_addr, ar_addr, w_data, w_strb} = 52'h0;
   end

   // One write with all byte strobes set
   task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] resp);
      wr_strb(a, d, 4'hF, resp);
   endtask

   // One write; returns right at the response edge so a follow-up is prompt
   task automatic wr_strb(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                          output logic [1:0] resp);
      logic ta;
      logic tw;
      ta = 1'h0;
      tw = 1'h0;
      aw_valid <= 1'h1;
      aw_addr  <= a;
      w_valid  <= 1'h1;
      w_data   <= d;
      w_strb   <= s;
      while (!(ta && tw)) begin
         @(posedge clk);
         // Released payload flips so stale values never look valid
         if (aw_valid && aw_ready) begin
            aw_valid <= 1'h0;
            aw_addr  <= ~a;
            ta = 1'h1;
         end
         if (w_valid && w_ready) begin
            w_valid <= 1'h0;
            w_data  <= ~d;
            tw = 1'h1;
         end
      end
      do @(posedge clk); while (!b_valid);
      resp = b_resp;
   endtask

   // One read; returns data and response code
   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
      ar_valid <= 1'h1;
      ar_addr  <= a;
      do @(posedge clk); while (!ar_ready);
      ar_valid <= 1'h0;
      ar_addr  <= ~a;
      do @(posedge clk); while (!r_valid);
      d = r_data;
      resp = r_resp;
   endtask

   // One completed instruction
   task automatic instr();
      done <= 1'h1;
      @(posedge clk);
      done <= 1'h0;
   endtask
endmodule // vtr_core_model

/* sim/vtr_top_tb.sv */
/*
 Testbench of the vector table relocation block with a core model.
 Assumes the core model and the design package files are compiled first.
*/
`timescale 1ns/100ps

module vtr_top_tb;
   logic        clk, rst, awv, awr, wv, wr_r, bv, arv, arr, rv, done;
   logic        app, boot, exe, vsel, blk, ce;
   logic [7:0]  awa, ara;
   logic [31:0] wd, rdat, q, v;
   logic [3:0]  ws;
   logic [1:0]  bresp, rresp, r;
   logic [15:0] base, ofs, vaddr;
   logic [4:0]  en;
   int          error_cnt, tests_run, seed;

   vtr_top u_vtr_top (.CORE_CLK(clk), .RST(rst), .CE(ce),
      .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr), .S_AXI_AWADDR(awa),
      .S_AXI_WVALID(wv), .S_AXI_WREADY(wr_r), .S_AXI_WDATA(wd), .S_AXI_WSTRB(ws),
      .S_AXI_BVALID(bv), .S_AXI_BREADY(1'h1), .S_AXI_BRESP(bresp),
      .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr), .S_AXI_ARADDR(ara),
      .S_AXI_RVALID(rv), .S_AXI_RREADY(1'h1), .S_AXI_RDATA(rdat), .S_AXI_RRESP(rresp),
      .INSTR_DONE(done), .APP_LOCK(app), .BOOT_LOCK(boot), .EXEC_BOOT(exe),
      .BOOT_BASE(base), .VEC_OFFSET(ofs), .IRQ_ENABLE(en), .VEC_SELECT(vsel),
      .VEC_ADDR(vaddr), .IRQ_BLOCK(blk));

   vtr_core_model u_vtr_core_model (.clk(clk), .aw_valid(awv), .aw_ready(awr),
      .aw_addr(awa), .w_valid(wv), .w_ready(wr_r), .w_data(wd), .w_strb(ws),
      .b_valid(bv), .b_resp(bresp), .ar_valid(arv), .ar_ready(arr), .ar_addr(ara),
      .r_valid(rv), .r_data(rdat), .r_resp(rresp), .done(done));

   // Clock
   always #5 clk = ~clk;

   // Expected register readback
   function automatic logic [31:0] exp_reg(input logic [31:0] d, input logic s);
      return {24'h0, d[7:3], 1'h0, s, 1'h0};
   endfunction

   // Compare and count
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         error_cnt++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // Verdict and end of run
   task automatic stop_test();
      $display("errors=%0d checks=%0d", error_cnt, tests_run);
      if (error_cnt == 0 && tests_run > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask

   // Unlock then select write, then let the mask go with one instruction
   task automatic move(input logic s);
      u_vtr_core_model.wr(8'h00, 32'h1, r);
      chk(blk, 1'h1);
      u_vtr_core_model.wr(8'h00, {30'h0, s, 1'h0}, r);
      chk(vsel, s);
      repeat (6) @(posedge clk);
      chk(blk, 1'h1);
      u_vtr_core_model.instr();
      repeat (2) @(posedge clk);
      chk(blk, 1'h0);
   endtask

   // Watchdog
   initial begin
      #100000;
      error_cnt++;
      stop_test();
   end

   // Main sequence
   initial begin
      {clk, app, boot, exe, error_cnt, tests_run} = '0;
      {base, ofs} = 32'h0;
      rst = 1'h1;
      ce = 1'h1;
      seed = $urandom(86);
      repeat (5) @(posedge clk);
      rst <= 1'h0;
      repeat (2) @(posedge clk);
      u_vtr_core_model.rd(8'h00, q, r);
      chk(q, 32'h0);
      // Closed window: enables written, select ignored
      for (int i = 0; i < 8; i++) begin
         v = $urandom & 32'hFFFFFFFE;
         u_vtr_core_model.wr(8'h00, v, r);
         u_vtr_core_model.rd(8'h00, q, r);
         chk(q, exp_reg(v, 1'h0));
         chk(en, v[7:3]);
      end
      move(1'h1);
      // Vector address for random offsets and bases
      for (int i = 0; i < 8; i++) begin
         ofs <= 16'($urandom);
         base <= 16'($urandom);
         repeat (2) @(posedge clk);
         chk(vaddr, 16'(ofs + ((i < 4) ? base : 16'h0)));
         if (i == 3) move(1'h0);
      end
      // Unlock with no select write: window and mask expire
      u_vtr_core_model.wr(8'h00, 32'h1, r);
      repeat (3) @(posedge clk);
      chk(blk, 1'h1);
      @(posedge clk);
      chk(blk, 1'h0);
      u_vtr_core_model.rd(8'h00, q, r);
      chk(q[0], 1'h0);
      u_vtr_core_model.wr(8'h00, 32'h2, r);
      chk(vsel, 1'h0);
      // Clock enable low stretches the window by the frozen cycles
      u_vtr_core_model.wr(8'h00, 32'h1, r);
      ce <= 1'h0;
      repeat (6) @(posedge clk);
      ce <= 1'h1;
      repeat (3) @(posedge clk);
      chk(blk, 1'h1);
      @(posedge clk);
      chk(blk, 1'h0);
      // Lock bits against execution section, both vector places
      for (int s = 0; s < 2; s++) begin
         move(s[0]);
         for (int k = 0; k < 8; k++) begin
            {app, boot, exe} <= k[2:0];
            repeat (2) @(posedge clk);
            chk(blk, s ? k[2] & ~k[0] : k[1] & k[0]);
         end
         {app, boot, exe} <= 3'h0;
      end
      // Reset in mid run, with the window open and select set
      u_vtr_core_model.wr(8'h00, 32'h1, r);
      rst <= 1'h1;
      @(posedge clk);
      rst <= 1'h0;
      repeat (2) @(posedge clk);
      chk(vsel, 1'h0);
      chk(blk, 1'h0);
      u_vtr_core_model.rd(8'h00, q, r);
      chk(q, 32'h0);
      // Unmapped address, then a write without byte 0
      u_vtr_core_model.wr(8'h04, 32'hFF, r);
      chk(r, 2'h2);
      chk(en, 5'h0);
      u_vtr_core_model.rd(8'h04, q, r);
      chk(q, 32'h0);
      chk(r, 2'h2);
      u_vtr_core_model.wr_strb(8'h00, 32'hF9, 4'hE, r);
      chk(r, 2'h0);
      chk(en, 5'h0);
      chk(blk, 1'h0);
      stop_test();
   end
endmodule // vtr_top_tb
